// ---- hdl/css_regs.svh ----
// register offsets, field positions, reset values and timing counts of the control source selector
`ifndef CSS_REGS_SVH
`define CSS_REGS_SVH
`define CSS_OFS_CAL 8'h0E
`define CSS_OFS_DIVSRC 8'h14
`define CSS_OFS_DIV0 8'h15
`define CSS_OFS_DIV3 8'h18
`define CSS_OFS_CRYSTAL_INPUT 8'h1B
`define CSS_OFS_REFCFG 8'h1C
`define CSS_OFS_STAT 8'h1D
`define CSS_OFS_OM1 8'h32
`define CSS_OFS_OM2 8'h34
`define CSS_BIT_CAL_EN 2
`define CSS_BIT_CAL_GO 7
`define CSS_BIT_DIV_EN 2
`define CSS_BIT_CRYSTAL_INPUT_PIN 7
`define CSS_BIT_REF_DIFF 0
`define CSS_BIT_REF_DIV5 1
`define CSS_BIT_REF_DBL 2
`define CSS_BIT_REF_EN 7
`define CSS_BIT_OM_EN 0
`define CSS_RST_ZERO 8'h00
`define CSS_RST_CRYSTAL_INPUT 8'hBF
`define CSS_CAP_STEP_FF 250
`define CSS_CAP_PIN_FF 2000
`define CSS_IN_SERIAL 4'h0
`define CSS_OUT_SERIAL 6'h00
`define CSS_CLK_PERIOD_NS 10
`define CSS_DET_WINDOW_NS 2000
`define CSS_DET_WINDOW_CYC (`CSS_DET_WINDOW_NS / `CSS_CLK_PERIOD_NS)
`endif

// ---- hdl/css_pkg.sv ----
// types shared by the control source selector modules
package css_pkg;
  // serial controller states, one-hot
  typedef enum logic [3:0] {
    CSS_IDLE = 4'h1,
    CSS_INSTR = 4'h2,
    CSS_WDATA = 4'h4,
    CSS_RDATA = 4'h8
  } css_ser_state_t;
  typedef logic [7:0] css_byte_t;
endpackage : css_pkg

// ---- hdl/css_reg_if.sv ----
// register access channel between serial controller and register file
`timescale 1ns/1ps
interface css_reg_if;
  logic wr_stb; // one-cycle write strobe
  logic [7:0] addr; // register offset
  logic [7:0] wdata; // write byte
  logic [7:0] rdata; // read byte for addr
  modport ctrl (output wr_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface : css_reg_if

// ---- hdl/css_presence_det.sv ----
// input presence detector sampled by the feedback clock
`timescale 1ns/1ps
`include "css_regs.svh"
module css_presence_det
  import css_pkg::*;
#(
  parameter int WIN = `CSS_DET_WINDOW_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sig,
  output logic present
);
  logic [2:0] sync_q, sync_d; // two sync stages plus edge history
  logic [15:0] cnt_q, cnt_d; // cycles since last edge
  logic present_q, present_d;
  // edge seen within the window means the input is alive
  always_comb begin
    sync_d = {sync_q[1:0], sig};
    cnt_d = cnt_q;
    if (sync_q[2] != sync_q[1]) begin
      cnt_d = 16'h0000;
    end else if (cnt_q != 16'hFFFF) begin
      cnt_d = cnt_q + 16'h0001;
    end
    present_d = (cnt_q < 16'(WIN));
  end
  // state registers; after reset nothing is assumed present
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_q <= 3'h0;
      cnt_q <= 16'hFFFF;
      present_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      cnt_q <= cnt_d;
      present_q <= present_d;
    end
  end
  assign present = present_q;
endmodule : css_presence_det

// ---- hdl/css_serial_ctrl.sv ----
// 3-wire serial controller, 16-bit instruction then one data byte, msb first
`timescale 1ns/1ps
module css_serial_ctrl
  import css_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  css_reg_if.ctrl bus
);
  css_ser_state_t state_q, state_d;
  logic sclk_q, sclk_d; // previous sclk sample
  logic [3:0] cnt_q, cnt_d; // bit counter
  logic [15:0] sh_q, sh_d; // shift register
  logic [7:0] addr_q, addr_d;
  logic oe_q, oe_d, out_q, out_d, wr_q, wr_d;
  logic rise, fall;
  // inputs arrive already synchronised; edges found against the previous sample
  always_comb begin
    rise = sclk & ~sclk_q;
    fall = ~sclk & sclk_q;
    state_d = state_q;
    sclk_d = sclk;
    cnt_d = cnt_q;
    sh_d = sh_q;
    addr_d = addr_q;
    oe_d = oe_q;
    out_d = out_q;
    wr_d = 1'b0;
    if (!enable || cs_n) begin // outside serial mode all traffic is ignored
      state_d = CSS_IDLE;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else begin
      case (state_q)
        CSS_IDLE: begin
          state_d = CSS_INSTR;
        end
        CSS_INSTR: begin
          if (rise) begin
            sh_d = {sh_q[14:0], sdio_i};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'hF) begin
              addr_d = {sh_q[6:0], sdio_i};
              state_d = sh_q[14] ? CSS_RDATA : CSS_WDATA; // first bit high means read
            end
          end
        end
        CSS_WDATA: begin
          if (rise) begin
            sh_d = {sh_q[14:0], sdio_i};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              wr_d = 1'b1; // byte lands in sh_q[7:0] with the strobe
              cnt_d = 4'h0;
              state_d = CSS_INSTR;
            end
          end
        end
        CSS_RDATA: begin
          if (fall) begin
            cnt_d = cnt_q + 4'h1;
            oe_d = 1'b1;
            if (cnt_q == 4'h0) begin
              out_d = bus.rdata[7];
              sh_d[7:0] = {bus.rdata[6:0], 1'b0};
            end else if (cnt_q == 4'h8) begin
              oe_d = 1'b0; // release after the last bit was sampled
              cnt_d = 4'h0;
              state_d = CSS_INSTR;
            end else begin
              out_d = sh_q[7];
              sh_d[7:0] = {sh_q[6:0], 1'b0};
            end
          end
        end
        default: begin
          state_d = CSS_IDLE;
        end
      endcase
    end
  end
  // state registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= CSS_IDLE;
      sclk_q <= 1'b0;
      cnt_q <= 4'h0;
      sh_q <= 16'h0000;
      addr_q <= 8'h00;
      oe_q <= 1'b0;
      out_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sclk_q <= sclk_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      oe_q <= oe_d;
      out_q <= out_d;
      wr_q <= wr_d;
    end
  end
  assign bus.wr_stb = wr_q;
  assign bus.addr = addr_q;
  assign bus.wdata = sh_q[7:0];
  assign sdio_o = out_q;
  assign sdio_oe = oe_q;
endmodule : css_serial_ctrl

// ---- hdl/css_top.sv ----
// control source selector: serial mode decode, shared pin mux, register file and function muxes
`timescale 1ns/1ps
`include "css_regs.svh"
module css_top
  import css_pkg::*;
#(
  parameter int DET_WIN = `CSS_DET_WINDOW_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] input_freq_select_pins,
  input wire logic [5:0] output_freq_select_pins,
  input wire logic [2:0] shared_serial_outmode_pins,
  output logic sdio_o,
  output logic sdio_oe,
  input wire logic primary_reference_input,
  input wire logic secondary_reference_input,
  input wire logic crystal_input,
  input wire logic [31:0] pin_div_values,
  input wire logic pin_cal_start,
  output logic serial_mode,
  output logic [31:0] div_values,
  output logic vco_cal_start,
  output logic vco_cal_reg_ctrl,
  output logic [5:0] crystal_input_cap_code,
  output logic ref_diff_mode,
  output logic ref_div5_en,
  output logic ref_dbl_en,
  output logic [2:0] out1_mode,
  output logic [2:0] second_clock_output_mode,
  output logic present_primary,
  output logic present_secondary,
  output logic present_crystal
);
  localparam logic [5:0] CAP_PIN_CODE = 6'(`CSS_CAP_PIN_FF / `CSS_CAP_STEP_FF); // 2 pF default

  // offset match, used by write decode and read mux
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // prescaler and doubler settings implied by the input select pins
  function automatic logic [1:0] ref_pin_decode(input logic [3:0] code);
    case (code)
      4'h1, 4'h6, 4'hC: ref_pin_decode = 2'h1; // doubler only
      4'hB: ref_pin_decode = 2'h3; // prescaler and doubler
      default: ref_pin_decode = 2'h0; // both bypassed
    endcase
  endfunction : ref_pin_decode

  // pin synchronisers; open pins are pulled high at the board, so they read one
  logic [12:0] pin_s1_q, pin_s2_q; // first stage feeds only the second
  logic [3:0] in_sel;
  logic [5:0] out_sel;
  logic [2:0] shared_s;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_s1_q <= 13'h1FFF;
      pin_s2_q <= 13'h1FFF;
    end else begin
      pin_s1_q <= {shared_serial_outmode_pins, output_freq_select_pins, input_freq_select_pins};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign in_sel = pin_s2_q[3:0];
  assign out_sel = pin_s2_q[9:4];
  assign shared_s = pin_s2_q[12:10];

  // serial mode decode and output-mode pin capture
  logic ser_q, ser_d; // serial mode
  logic [2:0] om_pin_q, om_pin_d; // pin-decoded output mode
  always_comb begin
    ser_d = (in_sel == `CSS_IN_SERIAL) || (out_sel == `CSS_OUT_SERIAL);
    om_pin_d = ser_q ? om_pin_q : shared_s;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ser_q <= 1'b0;
      om_pin_q <= 3'h0;
    end else begin
      ser_q <= ser_d;
      om_pin_q <= om_pin_d;
    end
  end

  // shared pin mux towards the serial controller: idle levels when not in serial mode
  logic ser_sclk, ser_cs_n, ser_sdio;
  always_comb begin
    ser_sclk = ser_q ? shared_s[0] : 1'b0;
    ser_cs_n = ser_q ? shared_s[1] : 1'b1;
    ser_sdio = ser_q ? shared_s[2] : 1'b0;
  end

  css_reg_if rif ();
  css_serial_ctrl u_ser (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(ser_q),
    .sclk(ser_sclk),
    .cs_n(ser_cs_n),
    .sdio_i(ser_sdio),
    .sdio_o(sdio_o),
    .sdio_oe(sdio_oe),
    .bus(rif.ctrl)
  );

  // register file; writes only arrive while in serial mode, and nothing clears
  // the registers when serial mode ends
  logic [7:0] cal_q, cal_d, divsrc_q, divsrc_d, crystal_input_q, crystal_input_d;
  logic [7:0] refcfg_q, refcfg_d, om1_q, om1_d, om2_q, om2_d;
  logic [7:0] div_q [4]; // divider value bytes
  logic [7:0] div_d [4];
  logic cal_go; // calibration command written
  logic [7:0] stat;
  always_comb begin
    cal_d = cal_q;
    divsrc_d = divsrc_q;
    crystal_input_d = crystal_input_q;
    refcfg_d = refcfg_q;
    om1_d = om1_q;
    om2_d = om2_q;
    div_d = div_q;
    cal_go = 1'b0;
    if (rif.wr_stb) begin
      if (hit(rif.addr, `CSS_OFS_CAL)) begin
        cal_d = rif.wdata;
        cal_d[`CSS_BIT_CAL_GO] = 1'b0; // command bit does not stick
        cal_go = rif.wdata[`CSS_BIT_CAL_GO] & rif.wdata[`CSS_BIT_CAL_EN];
      end
      if (hit(rif.addr, `CSS_OFS_DIVSRC)) begin
        divsrc_d = rif.wdata;
      end
      for (int i = 0; i < 4; i++) begin
        if (hit(rif.addr, `CSS_OFS_DIV0 + 8'(i))) begin
          div_d[i] = rif.wdata;
        end
      end
      if (hit(rif.addr, `CSS_OFS_CRYSTAL_INPUT)) begin
        crystal_input_d = rif.wdata & 8'hBF; // bit 6 reserved
      end
      if (hit(rif.addr, `CSS_OFS_REFCFG)) begin
        refcfg_d = rif.wdata;
      end
      if (hit(rif.addr, `CSS_OFS_OM1)) begin
        om1_d = rif.wdata;
      end
      if (hit(rif.addr, `CSS_OFS_OM2)) begin
        om2_d = rif.wdata;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cal_q <= `CSS_RST_ZERO;
      divsrc_q <= `CSS_RST_ZERO;
      crystal_input_q <= `CSS_RST_CRYSTAL_INPUT;
      refcfg_q <= `CSS_RST_ZERO;
      om1_q <= `CSS_RST_ZERO;
      om2_q <= `CSS_RST_ZERO;
      for (int i = 0; i < 4; i++) begin
        div_q[i] <= `CSS_RST_ZERO;
      end
    end else begin
      cal_q <= cal_d;
      divsrc_q <= divsrc_d;
      crystal_input_q <= crystal_input_d;
      refcfg_q <= refcfg_d;
      om1_q <= om1_d;
      om2_q <= om2_d;
      div_q <= div_d;
    end
  end

  // read mux; unmapped offsets read zero
  logic p_pri, p_sec, p_xtl;
  always_comb begin
    stat = {4'h0, ser_q, p_xtl, p_sec, p_pri};
    rif.rdata = 8'h00;
    if (hit(rif.addr, `CSS_OFS_CAL)) rif.rdata = cal_q;
    if (hit(rif.addr, `CSS_OFS_DIVSRC)) rif.rdata = divsrc_q;
    for (int i = 0; i < 4; i++) begin
      if (hit(rif.addr, `CSS_OFS_DIV0 + 8'(i))) rif.rdata = div_q[i];
    end
    if (hit(rif.addr, `CSS_OFS_CRYSTAL_INPUT)) rif.rdata = crystal_input_q;
    if (hit(rif.addr, `CSS_OFS_REFCFG)) rif.rdata = refcfg_q;
    if (hit(rif.addr, `CSS_OFS_STAT)) rif.rdata = stat;
    if (hit(rif.addr, `CSS_OFS_OM1)) rif.rdata = om1_q;
    if (hit(rif.addr, `CSS_OFS_OM2)) rif.rdata = om2_q;
  end

  // presence detectors, sampled by the feedback clock
  css_presence_det #(.WIN(DET_WIN)) u_det_pri (.clk_sys(clk_sys), .rst(rst), .sig(primary_reference_input),
    .present(p_pri));
  css_presence_det #(.WIN(DET_WIN)) u_det_sec (.clk_sys(clk_sys), .rst(rst), .sig(secondary_reference_input),
    .present(p_sec));
  css_presence_det #(.WIN(DET_WIN)) u_det_xtl (.clk_sys(clk_sys), .rst(rst), .sig(crystal_input),
    .present(p_xtl));

  // function muxes, each steered by an enable bit, prescaler and doubler by the same one; outputs registered
  logic [31:0] divv_q, divv_d;
  logic [5:0] cap_q, cap_d;
  logic [2:0] m1_q, m1_d, m2_q, m2_d;
  logic calst_q, calst_d, calen_q, calen_d, diff_q, diff_d, d5_q, d5_d, dbl_q, dbl_d;
  logic psec_q, psec_d, ppri_q, ppri_d, pxtl_q, pxtl_d;
  logic ref_en;
  // one pin decode shared by the prescaler and doubler selectors
  logic [1:0] ref_pin; // pin-decoded {prescaler, doubler}
  always_comb begin
    ref_en = refcfg_q[`CSS_BIT_REF_EN];
    ref_pin = ref_pin_decode(in_sel);
    divv_d = divsrc_q[`CSS_BIT_DIV_EN] ? {div_q[3], div_q[2], div_q[1], div_q[0]} : pin_div_values;
    calen_d = cal_q[`CSS_BIT_CAL_EN];
    // a byte carrying enable and command together starts at once, the old enable is not yet set
    calst_d = cal_go | (~calen_d & pin_cal_start);
    cap_d = crystal_input_q[`CSS_BIT_CRYSTAL_INPUT_PIN] ? CAP_PIN_CODE : crystal_input_q[5:0];
    // prescaler sits ahead of the doubler, doubler drives the phase detector
    d5_d = ref_en ? refcfg_q[`CSS_BIT_REF_DIV5] : ref_pin[1];
    dbl_d = ref_en ? refcfg_q[`CSS_BIT_REF_DBL] : ref_pin[0];
    diff_d = ref_en & refcfg_q[`CSS_BIT_REF_DIFF];
    m1_d = om1_q[`CSS_BIT_OM_EN] ? om1_q[3:1] : om_pin_q;
    m2_d = om2_q[`CSS_BIT_OM_EN] ? om2_q[3:1] : om_pin_q;
    ppri_d = p_pri;
    psec_d = p_sec & ~diff_d; // secondary pin is the complement, not a reference
    pxtl_d = p_xtl;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divv_q <= 32'h0000_0000;
      cap_q <= CAP_PIN_CODE;
      m1_q <= 3'h0;
      m2_q <= 3'h0;
      {calst_q, calen_q, diff_q, d5_q, dbl_q, psec_q, ppri_q, pxtl_q} <= 8'h00;
    end else begin
      divv_q <= divv_d;
      cap_q <= cap_d;
      m1_q <= m1_d;
      m2_q <= m2_d;
      {calst_q, calen_q, diff_q, d5_q, dbl_q, psec_q, ppri_q, pxtl_q} <=
        {calst_d, calen_d, diff_d, d5_d, dbl_d, psec_d, ppri_d, pxtl_d};
    end
  end
  assign serial_mode = ser_q;
  assign div_values = divv_q;
  assign vco_cal_start = calst_q;
  assign vco_cal_reg_ctrl = calen_q;
  assign crystal_input_cap_code = cap_q;
  assign ref_diff_mode = diff_q;
  assign ref_div5_en = d5_q;
  assign ref_dbl_en = dbl_q;
  assign out1_mode = m1_q;
  assign second_clock_output_mode = m2_q;
  assign present_primary = ppri_q;
  assign present_secondary = psec_q;
  assign present_crystal = pxtl_q;

  // checks
  ser_on_a: assert property (@(posedge clk_sys) disable iff (rst)
    (in_sel == 4'h0 || out_sel == 6'h00) |=> serial_mode) else $error("serial mode not entered");
  ser_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    (in_sel != 4'h0 && out_sel != 6'h00) |=> !serial_mode) else $error("serial mode not left");
  sdio_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    !serial_mode [*2] |-> !sdio_oe) else $error("sdio driven outside serial mode");
  om_freeze_a: assert property (@(posedge clk_sys) disable iff (rst)
    serial_mode |=> $stable(om_pin_q)) else $error("pin mode changed in serial mode");
  div_reg_a: assert property (@(posedge clk_sys) disable iff (rst)
    divsrc_q[2] |=> div_values == $past({div_q[3], div_q[2], div_q[1], div_q[0]}))
    else $error("divider not from registers");
  div_pin_a: assert property (@(posedge clk_sys) disable iff (rst)
    !divsrc_q[2] |=> div_values == $past(pin_div_values)) else $error("divider not from pins");
  cap_pin_a: assert property (@(posedge clk_sys) disable iff (rst)
    crystal_input_q[7] |=> crystal_input_cap_code == 6'h08) else $error("pin load cap not 2 pF");
  reset_en_a: assert property (@(posedge clk_sys) disable iff (rst)
    $past(rst) |-> !divsrc_q[2] && !cal_q[2] && crystal_input_q == 8'hBF && !refcfg_q[7] && !om1_q[0] && !om2_q[0])
    else $error("enable bits not cleared by reset");
  cal_go_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rif.wr_stb && rif.addr == 8'h0E && rif.wdata[7] && rif.wdata[2]) |=> vco_cal_start)
    else $error("calibration not started");
  sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    (divsrc_q[2] && !serial_mode) |=> divsrc_q[2]) else $error("register control lost");
  diff_sec_a: assert property (@(posedge clk_sys) disable iff (rst)
    ref_diff_mode |-> !present_secondary) else $error("secondary reported in differential mode");
endmodule : css_top

// ---- verif/css_host_model.sv ----
// behavioural host controller driving the 3-wire serial port
`timescale 1ns/1ps
module css_host_model (
  input wire logic clk_sys,
  input wire logic sdio_wire,
  output logic sclk,
  output logic cs_n,
  output logic sdio_drv
);
  // idle levels at time zero: frame closed, link clock low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdio_drv = 1'b0;
  end
  // half a link period is 8 system cycles, 80 ns
  task automatic half();
    repeat (8) @(posedge clk_sys);
  endtask : half
  // one instruction and one data byte, msb first; rd gets the byte shifted in
  task automatic xfer(input logic rw, input logic [7:0] ofs, input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] frame;
    frame = {rw, 7'h00, ofs, wd};
    rd = 8'h00;
    cs_n <= 1'b0;
    half();
    for (int i = 23; i >= 0; i--) begin
      // a released line moves every bit so a stale value never looks valid
      if (rw && i < 8) sdio_drv <= ~sdio_drv;
      else sdio_drv <= frame[i];
      half();
      sclk <= 1'b1;
      if (rw && i < 8) rd = {rd[6:0], sdio_wire}; // sampled on the rising edge
      half();
      sclk <= 1'b0;
    end
    half();
    cs_n <= 1'b1; // clock stands still between frames
    half();
  endtask : xfer
endmodule : css_host_model

// ---- verif/control_source_select_tb.sv ----
// self-checking bench for the control source selector
`timescale 1ns/1ps
module control_source_select_tb;
  import css_pkg::*;
  typedef struct {int k; logic [31:0] e;} css_note_t; // one expected result
  localparam int DWIN = 40; // short detector window keeps the run brief
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] in_sel = 4'h5; // open straps are modelled as ones
  logic [5:0] out_sel = 6'h11;
  logic [2:0] om_code = 3'h2; // output mode code while pins are not serial
  logic use_host = 1'b0; // host model owns the shared pins
  logic [2:0] ref_en = 3'h7; // {primary, secondary, crystal} running
  logic [2:0] refs = 3'h0;
  logic [31:0] pin_div = 32'h0;
  logic pin_cal = 1'b0;
  logic sclk, cs_n, sdio_drv, sdio_wire, sdio_o, sdio_oe, serial_mode, cal_start, cal_reg, diff, div5, dbl;
  logic [2:0] pins, om1, om2, pres;
  logic [31:0] div_values;
  logic [5:0] cap;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] cal_cnt = 8'h00; // calibration start pulses seen
  logic [3:0] ph = 4'h0;
  logic [7:0] b [4];
  logic [2:0] m1, m2;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  css_note_t q[$];
  css_note_t cur;
  event chk_ev;
  string nm[10] = '{"serial_mode", "div_values", "cal_reg_ctrl", "crystal_input_cap_code", "ref_path", "out1_mode",
                    "second_clock_output_mode", "presence", "read_data", "cal_pulses"};

  always #5 clk_sys = ~clk_sys;
  assign sdio_wire = sdio_oe ? sdio_o : sdio_drv; // device drives only while enabled
  assign pins = use_host ? {sdio_wire, cs_n, sclk} : om_code;

  css_host_model i_host (.clk_sys(clk_sys), .sdio_wire(sdio_wire), .sclk(sclk), .cs_n(cs_n), .sdio_drv(sdio_drv));
  css_top #(.DET_WIN(DWIN)) i_dut (.clk_sys(clk_sys), .rst(rst), .input_freq_select_pins(in_sel),
    .output_freq_select_pins(out_sel), .shared_serial_outmode_pins(pins), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
    .primary_reference_input(refs[2]), .secondary_reference_input(refs[1]), .crystal_input(refs[0]),
    .pin_div_values(pin_div), .pin_cal_start(pin_cal), .serial_mode(serial_mode), .div_values(div_values),
    .vco_cal_start(cal_start), .vco_cal_reg_ctrl(cal_reg), .crystal_input_cap_code(cap), .ref_diff_mode(diff),
    .ref_div5_en(div5), .ref_dbl_en(dbl), .out1_mode(om1), .second_clock_output_mode(om2), .present_primary(pres[2]),
    .present_secondary(pres[1]), .present_crystal(pres[0]));

  // reference clocks of 160 ns, pulse counter and hang guard
  always @(posedge clk_sys) begin
    ph <= ph + 4'h1;
    if (ph[2:0] == 3'h7) refs <= ref_en & ~refs;
    if (cal_start === 1'b1) cal_cnt <= cal_cnt + 8'h01;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      wrap_up();
    end
  end

  function automatic logic [31:0] obs(int k);
    case (k)
      0: return {31'h0, serial_mode};
      1: return div_values;
      2: return {31'h0, cal_reg};
      3: return {26'h0, cap};
      4: return {29'h0, diff, div5, dbl};
      5: return {29'h0, om1};
      6: return {29'h0, om2};
      7: return {29'h0, pres};
      8: return {24'h0, rd_data};
      default: return {24'h0, cal_cnt};
    endcase
  endfunction : obs

  // monitor: oldest note first, once the driver says outputs have settled
  always @(chk_ev) begin
    while (q.size() > 0) begin
      cur = q.pop_front();
      cmp_count++;
      if (obs(cur.k) !== cur.e) begin
        n_fail++;
        $display("mismatch %s expected %h seen %h", nm[cur.k], cur.e, obs(cur.k));
      end
    end
  end

  task automatic note(input int k, input logic [31:0] e);
    q.push_back('{k, e});
  endtask : note
  // sample away from the launching edge
  task automatic check();
    @(negedge clk_sys);
    -> chk_ev;
    @(posedge clk_sys);
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] junk;
    i_host.xfer(1'b0, a, d, junk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_host.xfer(1'b1, a, 8'h00, rd_data);
    note(8, {24'h0, e});
    check();
  endtask : rd
  task automatic wait_serial(input logic v);
    for (int n = 0; n < 20 && serial_mode !== v; n++) @(posedge clk_sys);
    note(0, {31'h0, v});
    check();
  endtask : wait_serial
  // host clock and select idle at the levels the mode code already shows, so hand-over makes no clock or select edge
  task automatic go_serial();
    om_code <= 3'h2;
    in_sel <= 4'h0;
    wait_serial(1'b1);
    repeat (4) @(posedge clk_sys);
    use_host <= 1'b1;
  endtask : go_serial
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  initial begin
    void'($urandom(44));
    pin_div <= $urandom();
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    pin_cal <= 1'b1;
    @(posedge clk_sys);
    pin_cal <= 1'b0;
    repeat (3) @(posedge clk_sys);
    note(1, pin_div);
    note(3, 32'h08);
    note(5, 32'h2);
    note(9, 32'h1);
    check();
    $display("test reset_state done");
    // strap decode table, last entry all pins open
    for (int i = 0; i < 5; i++) begin
      in_sel <= i[0] ? 4'h0 : (i == 4 ? 4'hF : 4'h1 + 4'($urandom_range(0, 14)));
      out_sel <= i[1] ? 6'h00 : (i == 4 ? 6'h3F : 6'h01 + 6'($urandom_range(0, 62)));
      repeat (8) @(posedge clk_sys);
      note(0, {31'h0, i[0] | i[1]});
      check();
    end
    in_sel <= 4'hB; // strapped for prescaler and doubler both on
    repeat (8) @(posedge clk_sys);
    note(4, 32'h3);
    check();
    $display("test strap_decode done");
    use_host <= 1'b1;
    wr(8'h14, 8'h04);
    use_host <= 1'b0;
    note(1, pin_div);
    note(5, 32'h2);
    check();
    $display("test port_inert done");
    go_serial();
    for (int i = 0; i < 4; i++) begin
      b[i] = 8'($urandom());
      wr(8'h15 + 8'(i), b[i]);
    end
    note(1, pin_div);
    check();
    wr(8'h14, 8'h04);
    note(1, {b[3], b[2], b[1], b[0]});
    note(5, 32'h2);
    check();
    rd(8'h14, 8'h04);
    rd(8'h17, b[2]);
    rd(8'h40, 8'h00);
    $display("test dividers done");
    wr(8'h0E, 8'h04);
    note(2, 32'h1);
    note(9, {24'h0, cal_cnt} + 32'h1);
    wr(8'h0E, 8'h84);
    rd(8'h0E, 8'h04);
    $display("test calibration done");
    rd(8'h1B, 8'hBF);
    wr(8'h1B, 8'h3F);
    note(3, 32'h3F);
    check();
    wr(8'h1B, 8'h28);
    note(3, 32'h28);
    check();
    $display("test crystal_load done");
    for (int c = 1; c < 8; c++) begin
      wr(8'h1C, 8'h80 | 8'(c));
      note(4, {29'h0, c[0], c[1], c[2]});
      note(7, {29'h0, 1'b1, ~c[0], 1'b1});
      check();
    end
    rd(8'h1D, 8'h0F);
    ref_en <= 3'h6;
    repeat (4 * DWIN) @(posedge clk_sys);
    note(7, 32'h4);
    check();
    $display("test references done");
    m1 = 3'($urandom());
    m2 = 3'($urandom());
    wr(8'h32, {4'h0, m1, 1'b1});
    wr(8'h34, {4'h0, m2, 1'b1});
    note(5, {29'h0, m1});
    note(6, {29'h0, m2});
    check();
    $display("test output_modes done");
    in_sel <= 4'h5;
    wait_serial(1'b0);
    use_host <= 1'b0;
    om_code <= 3'($urandom());
    pin_div <= $urandom();
    repeat (8) @(posedge clk_sys);
    note(1, {b[3], b[2], b[1], b[0]});
    note(3, 32'h28);
    note(5, {29'h0, m1});
    check();
    go_serial();
    rd(8'h15, b[0]);
    wr(8'h14, 8'h00);
    note(1, pin_div);
    check();
    $display("test leave_serial done");
    wrap_up();
  end
endmodule : control_source_select_tb
